// ### hslm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module hslm_far_model #(parameter int W = 20) (
    // Clock.
    input  wire logic           clk,
    // Controller transmit words and lane receive words.
    output wire logic [4*W-1:0] pcie_tx,
    output wire logic [2*W-1:0] sata_tx,
    output wire logic [2*W-1:0] disp_tx,
    output wire logic [W-1:0]   first_usb_controller_tx,
    output wire logic [W-1:0]   second_usb_controller_tx,
    output wire logic [4*W-1:0] eth_tx,
    output wire logic [4*W-1:0] lane_rx
);
    // Every channel streams at once with a distinct word each cycle, so a
    // stale or misrouted word never matches by chance.
    logic [15:0] cnt = 16'h0000;
    function automatic logic [W-1:0] word(input logic [15:0] c, input logic [3:0] id);
        return W'({c, id});
    endfunction
    always @(posedge clk) cnt <= cnt + 16'h0001;
    assign pcie_tx = {word(cnt, 4'h3), word(cnt, 4'h2), word(cnt, 4'h1), word(cnt, 4'h0)};
    assign sata_tx = {word(cnt, 4'h5), word(cnt, 4'h4)};
    assign disp_tx = {word(cnt, 4'h7), word(cnt, 4'h6)};
    assign first_usb_controller_tx = word(cnt, 4'h8);
    assign second_usb_controller_tx = word(cnt, 4'h9);
    assign eth_tx  = {word(cnt, 4'hD), word(cnt, 4'hC), word(cnt, 4'hB), word(cnt, 4'hA)};
    assign lane_rx = {word(~cnt, 4'h3), word(~cnt, 4'h2), word(~cnt, 4'h1), word(~cnt, 4'h0)};
endmodule
`default_nettype wire

// ### hslm_lane_mux.v
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hslm_map.vh"

module hslm_lane_mux #(
    parameter W = 20
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             rst,
    // Wishbone classic slave.
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    // Controller transmit data.
    input  wire [4*W-1:0]   pcie_tx,
    input  wire [2*W-1:0]   sata_tx,
    input  wire [2*W-1:0]   disp_tx,
    input  wire [W-1:0]     first_usb_controller_tx,
    input  wire [W-1:0]     second_usb_controller_tx,
    input  wire [4*W-1:0]   eth_tx,
    // Controller receive data and connection flags.
    output reg  [4*W-1:0]   pcie_rx,
    output reg  [2*W-1:0]   sata_rx,
    output reg  [W-1:0]     first_usb_controller_rx,
    output reg  [W-1:0]     second_usb_controller_rx,
    output reg  [4*W-1:0]   eth_rx,
    output reg  [3:0]       pcie_conn,
    output reg  [1:0]       sata_conn,
    output reg  [1:0]       disp_conn,
    output reg              first_usb_controller_conn,
    output reg              second_usb_controller_conn,
    output reg  [3:0]       eth_conn,
    // Transceiver lanes.
    output reg  [4*W-1:0]   lane_tx,
    output reg  [3:0]       lane_tx_en,
    output reg  [7:0]       lane_rate,
    input  wire [4*W-1:0]   lane_rx
);

    // ======================================================================
    // Configuration registers.
    reg  [15:0]  proto_reg;
    reg  [7:0]   rate_reg;
    reg  [2:0]   width_reg;
    reg  [15:0]  eff_reg;
    reg  [15:0]  eff_next;
    reg  [3:0]   act_next;
    reg  [3:0]   act_reg;

    wire         wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer      b;
        begin
            merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
        end
    endfunction

    // Byte-merged write words; only the low bits of each land in a register.
    wire [31:0]  proto_wr = merge({16'h0000, proto_reg}, wb_dat_i, wb_sel_i);
    wire [31:0]  rate_wr  = merge({24'h00_0000, rate_reg}, wb_dat_i, wb_sel_i);
    wire [31:0]  width_wr = merge({29'h0000_0000, width_reg}, wb_dat_i, wb_sel_i);

    // Whether a protocol may sit on a lane at a rate code.
    function legal;
        input [3:0] code;
        input [1:0] lane;
        input [1:0] rate;
        input [2:0] width;
        begin
            case (code)
                `HSLM_PROTO_PCIE: legal = (rate <= `HSLM_RATE_1) &&
                    ((width == `HSLM_PCIE_X1 && lane == 2'd0) ||
                     (width == `HSLM_PCIE_X2 && lane <= 2'd1) ||
                     (width == `HSLM_PCIE_X4));
                `HSLM_PROTO_SATA: legal = (rate <= `HSLM_RATE_2);
                `HSLM_PROTO_DISP: legal = (rate <= `HSLM_RATE_2);
                `HSLM_PROTO_FIRST_USB_CONTROLLER: legal = (rate == `HSLM_RATE_0) && (lane != 2'd3);
                `HSLM_PROTO_SECOND_USB_CONTROLLER: legal = (rate == `HSLM_RATE_0) && (lane == 2'd3);
                `HSLM_PROTO_ETH:  legal = (rate == `HSLM_RATE_0);
                default:          legal = 1'b0;
            endcase
        end
    endfunction

    // ======================================================================
    // Register access. Unmapped addresses are acknowledged and read zero.
    always @(posedge clk) begin
        if (rst) begin
            proto_reg <= `HSLM_RST_PROTO;
            rate_reg  <= `HSLM_RST_RATE;
            width_reg <= `HSLM_RST_WIDTH;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && wb_we_i) begin
                case (wb_adr_i)
                    `HSLM_ADDR_LANE_PROTO: proto_reg <= proto_wr[15:0];
                    `HSLM_ADDR_LANE_RATE:  rate_reg  <= rate_wr[7:0];
                    `HSLM_ADDR_PCIE_WIDTH: width_reg <= width_wr[2:0];
                    default: ;
                endcase
            end
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `HSLM_ADDR_LANE_PROTO: wb_dat_o <= {16'h0000, proto_reg};
                    `HSLM_ADDR_LANE_RATE:  wb_dat_o <= {24'h00_0000, rate_reg};
                    `HSLM_ADDR_PCIE_WIDTH: wb_dat_o <= {29'h0000_0000, width_reg};
                    `HSLM_ADDR_STATUS:     wb_dat_o <= {12'h000, eff_reg, act_reg};
                    default:               wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ======================================================================
    // Effective lane assignment. When software asks for one channel on two
    // lanes, the lower lane keeps it and the upper lane is left idle, so a
    // bad setting never drives one controller onto two lanes.
    integer l;
    integer k;
    reg     taken;
    always @* begin
        eff_next = 16'h0000;
        act_next = 4'h0;
        taken    = 1'b0;
        for (l = 0; l < 4; l = l + 1) begin
            if (legal(proto_reg[l*4 +: 4], l[1:0], rate_reg[l*2 +: 2], width_reg)) begin
                taken = 1'b0;
                for (k = 0; k < l; k = k + 1) begin
                    if (act_next[k] && eff_next[k*4 +: 4] == proto_reg[l*4 +: 4]) begin
                        if (proto_reg[l*4 +: 4] == `HSLM_PROTO_FIRST_USB_CONTROLLER ||
                            ((proto_reg[l*4 +: 4] == `HSLM_PROTO_SATA ||
                              proto_reg[l*4 +: 4] == `HSLM_PROTO_DISP) &&
                             k == l - 2)) begin
                            taken = 1'b1;
                        end
                    end
                end
                if (!taken) begin
                    act_next[l]        = 1'b1;
                    eff_next[l*4 +: 4] = proto_reg[l*4 +: 4];
                end
            end
        end
    end

    // ======================================================================
    // Registered data path, one cycle from controller to lane and back.
    integer n;
    always @(posedge clk) begin
        if (rst) begin
            eff_reg    <= 16'h0000;
            act_reg    <= 4'h0;
            lane_tx    <= {4*W{1'b0}};
            lane_tx_en <= 4'h0;
            lane_rate  <= 8'h00;
            pcie_rx    <= {4*W{1'b0}};
            sata_rx    <= {2*W{1'b0}};
            first_usb_controller_rx    <= {W{1'b0}};
            second_usb_controller_rx    <= {W{1'b0}};
            eth_rx     <= {4*W{1'b0}};
            pcie_conn  <= 4'h0;
            sata_conn  <= 2'h0;
            disp_conn  <= 2'h0;
            first_usb_controller_conn  <= 1'b0;
            second_usb_controller_conn  <= 1'b0;
            eth_conn   <= 4'h0;
        end else begin
            eff_reg    <= eff_next;
            act_reg    <= act_next;
            lane_rate  <= rate_reg & {{2{act_reg[3]}}, {2{act_reg[2]}},
                                      {2{act_reg[1]}}, {2{act_reg[0]}}};
            pcie_rx    <= {4*W{1'b0}};
            sata_rx    <= {2*W{1'b0}};
            first_usb_controller_rx    <= {W{1'b0}};
            second_usb_controller_rx    <= {W{1'b0}};
            eth_rx     <= {4*W{1'b0}};
            pcie_conn  <= 4'h0;
            sata_conn  <= 2'h0;
            disp_conn  <= 2'h0;
            first_usb_controller_conn  <= 1'b0;
            second_usb_controller_conn  <= 1'b0;
            eth_conn   <= 4'h0;
            for (n = 0; n < 4; n = n + 1) begin
                lane_tx_en[n]    <= act_reg[n];
                lane_tx[n*W +: W] <= {W{1'b0}};
                case (eff_reg[n*4 +: 4])
                    `HSLM_PROTO_PCIE: begin
                        lane_tx[n*W +: W] <= pcie_tx[n*W +: W];
                        pcie_rx[n*W +: W] <= lane_rx[n*W +: W];
                        pcie_conn[n]      <= 1'b1;
                    end
                    `HSLM_PROTO_SATA: begin
                        lane_tx[n*W +: W]       <= sata_tx[(n%2)*W +: W];
                        sata_rx[(n%2)*W +: W]   <= lane_rx[n*W +: W];
                        sata_conn[n%2]          <= 1'b1;
                    end
                    `HSLM_PROTO_DISP: begin
                        // Transmit only: the lane's receive side is ignored.
                        lane_tx[n*W +: W]       <= disp_tx[(1-n%2)*W +: W];
                        disp_conn[1-n%2]        <= 1'b1;
                    end
                    `HSLM_PROTO_FIRST_USB_CONTROLLER: begin
                        lane_tx[n*W +: W] <= first_usb_controller_tx;
                        first_usb_controller_rx           <= lane_rx[n*W +: W];
                        first_usb_controller_conn         <= 1'b1;
                    end
                    `HSLM_PROTO_SECOND_USB_CONTROLLER: begin
                        lane_tx[n*W +: W] <= second_usb_controller_tx;
                        second_usb_controller_rx           <= lane_rx[n*W +: W];
                        second_usb_controller_conn         <= 1'b1;
                    end
                    `HSLM_PROTO_ETH: begin
                        lane_tx[n*W +: W] <= eth_tx[n*W +: W];
                        eth_rx[n*W +: W]  <= lane_rx[n*W +: W];
                        eth_conn[n]       <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### hslm_lane_mux_props.sv
`timescale 1ns/1ps
`default_nettype none
module hslm_lane_mux_props #(parameter int W = 20) (
    // Clock, reset and bus handshake.
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           wb_cyc_i,
    input wire logic           wb_stb_i,
    input wire logic           wb_ack_o,
    // Controller side.
    input wire logic [4*W-1:0] pcie_tx,
    input wire logic [W-1:0]   second_usb_controller_tx,
    input wire logic [4*W-1:0] eth_tx,
    input wire logic [W-1:0]   second_usb_controller_rx,
    input wire logic [3:0]     pcie_conn,
    input wire logic [1:0]     sata_conn,
    input wire logic [1:0]     disp_conn,
    input wire logic           first_usb_controller_conn,
    input wire logic           second_usb_controller_conn,
    input wire logic [3:0]     eth_conn,
    // Lane side.
    input wire logic [4*W-1:0] lane_tx,
    input wire logic [3:0]     lane_tx_en,
    input wire logic [7:0]     lane_rate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==================================================
    // Idle lanes must be silent, so one flag covers all four.
    logic idle_ok;
    always_comb begin
        idle_ok = 1'b1;
        for (int i = 0; i < 4; i++)
            if (!lane_tx_en[i] && (lane_tx[i*W+:W] != '0 || lane_rate[2*i+:2] != 2'h0))
                idle_ok = 1'b0;
    end
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    AST_ACK_NEXT: assert property (s_req |=> s_ans)
        else $error("ack did not follow a request as one pulse");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_ONE_PER_LANE: assert property ($countones({pcie_conn, sata_conn, disp_conn,
        first_usb_controller_conn, second_usb_controller_conn, eth_conn}) == $countones(lane_tx_en))
        else $error("channel count differs from active lane count");
    AST_IDLE_QUIET: assert property (idle_ok)
        else $error("idle lane carries data or rate");
    AST_ETH_LANE: assert property (eth_conn[2] && $past(eth_conn[2])
        |-> lane_tx[2*W+:W] == $past(eth_tx[2*W+:W])) else $error("ethernet word off lane");
    AST_SECOND_USB_CONTROLLER_LANE3: assert property (second_usb_controller_conn && $past(second_usb_controller_conn)
        |-> lane_tx[3*W+:W] == $past(second_usb_controller_tx)) else $error("second usb word off lane");
    AST_PCIE_LANE: assert property (pcie_conn[1] && $past(pcie_conn[1])
        |-> lane_tx[W+:W] == $past(pcie_tx[W+:W])) else $error("pcie word off lane");
    AST_SECOND_USB_CONTROLLER_RX_ZERO: assert property (!second_usb_controller_conn |-> second_usb_controller_rx == '0)
        else $error("unconnected usb sees data");
endmodule
`default_nettype wire

// ### hslm_map.vh
// Summary of operation
// - Four transceiver lanes exist; each lane carries at most one controller channel.
// - Software-written registers steer routing; software must pick a permitted assignment.
// - Each lane selects its own protocol, so several standards run together.
// - PCI Express lanes run at 2.5 or 5.0 Gb/s as configured.
// - Two SATA channels; channel 0 on lane 0 or 2, channel 1 on 1 or 3.
// - SATA channels run at 1.5, 3.0 or 6.0 Gb/s as configured.
// - DisplayPort is transmit only; stream lane 1 on lane 0/2, lane 0 on 1/3.
// - DisplayPort lanes run at 1.62, 2.7 or 5.4 Gb/s as configured.
// - USB 3.0 at 5.0 Gb/s; first controller lanes 0-2, second only lane 3.
// - Up to four SGMII ports at 1.25 Gb/s; port n only on lane n.
`ifndef HSLM_MAP_VH
`define HSLM_MAP_VH

// ==========================================================================
// Register byte addresses.
`define HSLM_ADDR_LANE_PROTO  8'h00
`define HSLM_ADDR_LANE_RATE   8'h04
`define HSLM_ADDR_PCIE_WIDTH  8'h08
`define HSLM_ADDR_STATUS      8'h0C

// ==========================================================================
// Protocol codes held per lane in the lane protocol register.
`define HSLM_PROTO_NONE  4'h0
`define HSLM_PROTO_PCIE  4'h1
`define HSLM_PROTO_SATA  4'h2
`define HSLM_PROTO_DISP  4'h3
`define HSLM_PROTO_FIRST_USB_CONTROLLER  4'h4
`define HSLM_PROTO_SECOND_USB_CONTROLLER  4'h5
`define HSLM_PROTO_ETH   4'h6

// ==========================================================================
// Rate codes held per lane; meaning depends on the lane protocol.
`define HSLM_RATE_0  2'h0
`define HSLM_RATE_1  2'h1
`define HSLM_RATE_2  2'h2

// ==========================================================================
// Field widths and reset values.
`define HSLM_PROTO_W      4
`define HSLM_RATE_W       2
`define HSLM_WIDTH_W      3
`define HSLM_PCIE_X1      3'h1
`define HSLM_PCIE_X2      3'h2
`define HSLM_PCIE_X4      3'h4
`define HSLM_RST_PROTO    16'h0000
`define HSLM_RST_RATE     8'h00
`define HSLM_RST_WIDTH    3'h1

`endif

// ### test_hslm_lane_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "hslm_map.vh"
module test_hslm_lane_mux;
    localparam int W = 20;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, uc0, uc1;
    logic [7:0] adr = 8'h00, lrate;
    logic [3:0] sel = 4'h0, pc, ec, en;
    logic [31:0] dat = 32'h0000_0000, dout, q;
    logic [4*W-1:0] ptx, etx, prx, erx, ltx, lrx;
    logic [2*W-1:0] stx, dtx, srx;
    logic [W-1:0] u0tx, u1tx, u0rx, u1rx, hu0;
    logic [4*W-1:0] hp, he, hl;
    logic [2*W-1:0] hs, hd;
    logic [1:0] sc, dc;
    int bad_count = 0, checks_done = 0;
    typedef struct {logic [15:0] p; logic [7:0] r; logic [2:0] w;
        logic [3:0] en; logic [15:0] eff; logic [7:0] lr;} hslm_row_t;
    hslm_row_t rows [8] = '{'{16'h1111, 8'h55, 3'h4, 4'hF, 16'h1111, 8'h55},
        '{16'h5211, 8'h20, 3'h2, 4'hF, 16'h5211, 8'h20}, '{16'h6666, 8'h00, 3'h1, 4'hF, 16'h6666, 8'h00},
        '{16'h2433, 8'h46, 3'h1, 4'hF, 16'h2433, 8'h46}, '{16'h4265, 8'h30, 3'h1, 4'h2, 16'h0060, 8'h00},
        '{16'h3232, 8'h00, 3'h1, 4'h3, 16'h0032, 8'h00}, '{16'h1111, 8'h00, 3'h3, 4'h0, 16'h0000, 8'h00},
        '{16'h0000, 8'h00, 3'h1, 4'h0, 16'h0000, 8'h00}};
    always #5 clk = ~clk;
    hslm_lane_mux #(.W(W)) DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .pcie_tx(ptx), .sata_tx(stx), .disp_tx(dtx), .first_usb_controller_tx(u0tx), .second_usb_controller_tx(u1tx), .eth_tx(etx),
        .pcie_rx(prx), .sata_rx(srx), .first_usb_controller_rx(u0rx), .second_usb_controller_rx(u1rx), .eth_rx(erx), .pcie_conn(pc),
        .sata_conn(sc), .disp_conn(dc), .first_usb_controller_conn(uc0), .second_usb_controller_conn(uc1), .eth_conn(ec),
        .lane_tx(ltx), .lane_tx_en(en), .lane_rate(lrate), .lane_rx(lrx));
    hslm_far_model #(.W(W)) far (.clk(clk), .pcie_tx(ptx), .sata_tx(stx), .disp_tx(dtx),
        .first_usb_controller_tx(u0tx), .second_usb_controller_tx(u1tx), .eth_tx(etx), .lane_rx(lrx));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // The answer is taken at the rising edge that samples ack high, then released.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        n = 0;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin bad_count++; summarize(); end
        q = dout;
        {cyc, stb} <= 2'b00;
    endtask
    // Latch the stimulus just after one edge; the next edge moves it through the mux.
    task automatic step;
        @(posedge clk);
        #1 {hp, he, hl, hs, hd, hu0} = {ptx, etx, lrx, stx, dtx, u0tx};
        @(posedge clk);
        #1;
    endtask
    task automatic cfg(input hslm_row_t r);
        wb(1'b1, `HSLM_ADDR_LANE_PROTO, {16'h0000, r.p}, 4'hF);
        wb(1'b1, `HSLM_ADDR_LANE_RATE, {24'h00_0000, r.r}, 4'hF);
        wb(1'b1, `HSLM_ADDR_PCIE_WIDTH, {29'h0, r.w}, 4'hF);
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cfg(rows[i]);
            wb(1'b0, `HSLM_ADDR_STATUS, 32'h0000_0000, 4'hF);
            chk("status", q, {12'h000, rows[i].eff, rows[i].en});
            #1 chk("lane_en", 32'(en), 32'(rows[i].en));
            chk("lane_rate", 32'(lrate), 32'(rows[i].lr));
            $display("row %0d done", i);
        end
        cfg(rows[2]);
        step();
        chk("eth_lane", 32'(ltx[W+:W]), 32'(he[W+:W]));
        chk("eth_rx", 32'(erx[3*W+:W]), 32'(hl[3*W+:W]));
        chk("eth_conn", 32'(ec), 32'h0000_000F);
        cfg(rows[3]);
        step();
        chk("disp_lane0", 32'(ltx[0+:W]), 32'(hd[W+:W]));
        chk("disp_lane1", 32'(ltx[W+:W]), 32'(hd[0+:W]));
        chk("disp_conn", 32'(dc), 32'h0000_0003);
        chk("first_usb_controller_lane", 32'(ltx[2*W+:W]), 32'(hu0));
        chk("first_usb_controller_rx_on", 32'(u0rx), 32'(hl[2*W+:W]));
        chk("serial_ata_channel_one_lane", 32'(ltx[3*W+:W]), 32'(hs[W+:W]));
        chk("serial_ata_channel_one_rx", 32'(srx[W+:W]), 32'(hl[3*W+:W]));
        chk("pcie_idle_rx", 32'(prx[W+:W]), 32'h0000_0000);
        cfg(rows[1]);
        step();
        chk("sata_lane", 32'(ltx[2*W+:W]), 32'(hs[0+:W]));
        chk("sata_rx", 32'(srx[0+:W]), 32'(hl[2*W+:W]));
        chk("conn", 32'({sc, uc0, uc1}), 32'h0000_0005);
        chk("first_usb_controller_rx", 32'(u0rx), 32'h0000_0000);
        chk("pcie_lane", 32'(ltx[0+:W]), 32'(hp[0+:W]));
        chk("pcie_rx", 32'(prx[W+:W]), 32'(hl[W+:W]));
        chk("pcie_conn", 32'(pc), 32'h0000_0003);
        chk("eth_idle_rx", 32'(erx[0+:W]), 32'h0000_0000);
        $display("data path done");
        wb(1'b1, `HSLM_ADDR_LANE_PROTO, 32'h0000_6666, 4'hF);
        wb(1'b1, `HSLM_ADDR_LANE_PROTO, 32'hFFFF_1111, 4'h1);
        wb(1'b1, `HSLM_ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        wb(1'b0, `HSLM_ADDR_LANE_PROTO, 32'h0000_0000, 4'hF);
        chk("sel_mask", q, 32'h0000_6611);
        wb(1'b0, `HSLM_ADDR_STATUS, 32'h0000_0000, 4'hF);
        chk("status_ro", q, 32'h0006_011B);
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
        chk("unmapped", q, 32'h0000_0000);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("rst_en", 32'(en), 32'h0000_0000);
        wb(1'b0, `HSLM_ADDR_PCIE_WIDTH, 32'h0000_0000, 4'hF);
        chk("rst_width", q, 32'(`HSLM_RST_WIDTH));
        $display("register and reset tests done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
bind hslm_lane_mux hslm_lane_mux_props #(.W(W)) u_props (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pcie_tx(pcie_tx),
    .second_usb_controller_tx(second_usb_controller_tx), .eth_tx(eth_tx), .second_usb_controller_rx(second_usb_controller_rx), .pcie_conn(pcie_conn),
    .sata_conn(sata_conn), .disp_conn(disp_conn), .first_usb_controller_conn(first_usb_controller_conn), .second_usb_controller_conn(second_usb_controller_conn),
    .eth_conn(eth_conn), .lane_tx(lane_tx), .lane_tx_en(lane_tx_en), .lane_rate(lane_rate));
`default_nettype wire
